// File: bench/mgmt_master.sv
// Management controller model issuing serial register frames
`timescale 1ns/1ps
module mgmt_master (
  // Clock
  input wire logic pclk,
  // Management pins
  output logic mdc,
  output logic md_out,
  output logic md_oe,
  input wire logic md_in
);
  initial begin
    mdc = 1'b0;
    md_out = 1'b1;
    md_oe = 1'b0;
  end

  // One frame, half is the clock phase in pclk cycles
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, input int half, output logic [15:0] q);
    logic [63:0] w;
    w = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
    for (int i = 63; i >= -1; i--) begin
      @(posedge pclk);
      md_oe <= (i >= 0) && (!rd || i >= 18);
      md_out <= (i >= 0) ? w[i] : 1'b1;
      repeat (half) @(posedge pclk);
      // Sample at the rising edge, before the slave shifts its next bit
      if (i >= 0 && i < 16) q[i] = md_in;
      mdc <= 1'b1;
      repeat (half) @(posedge pclk);
      mdc <= 1'b0;
    end
  endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the diagnostic and power control block
`timescale 1ns/1ps
`include "phy_diag_consts.svh"
module testbench;
  typedef struct {
    logic wr;
    logic [4:0] idx;
    logic [15:0] wd;
    logic lnk;
    logic [15:0] rb;
    logic err;
    logic [6:0] outs;
  } row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mdc, mdio_i, mdio_o, mdio_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic link_up, auto_mdix_pair, partner_silent, echo_open, echo_short, tdr_pulse;
  logic [9:0] nand_pins;
  logic tdr_pair_mdix, txd1_o, txd1_oe, nand_mode, remote_loopback, power_save_active;
  logic energy_detect_powerdown, pll_off, powered_down, slow_osc_sel, soft_reset_pulse;
  logic m_out, m_oe, e;
  logic [15:0] q, h;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int resets = 0;
  row_type rows[16];
  logic [1:0] res[3];

  // Pin level: driver wins, pull-up when released
  assign mdio_i = mdio_oe ? mdio_o : (m_oe ? m_out : 1'b1);

  phy_diag_power_control phy_diag_power_control_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mdc, .mdio_i, .mdio_o, .mdio_oe,
    .phy_addr(5'h03), .link_up, .auto_mdix_pair, .partner_silent, .echo_open, .echo_short,
    .tdr_pulse, .tdr_pair_mdix, .nand_pins, .txd1_o, .txd1_oe, .nand_mode, .remote_loopback,
    .power_save_active, .energy_detect_powerdown, .pll_off, .powered_down, .slow_osc_sel,
    .soft_reset_pulse);
  mgmt_master mgmt_master_inst (.pclk, .mdc, .md_out(m_out), .md_oe(m_oe), .md_in(mdio_i));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Cycle ceiling and soft reset pulse count
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (soft_reset_pulse === 1'b1) resets <= resets + 1;
    if (cyc == 40000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // APB transfer, result left in q and e
  task automatic apb(input logic wr, input logic [4:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {5'h00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n == 40) chk("pready", 16'h0000, 16'h0001);
    q = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // poll busy until the test ends
  task automatic poll();
    int n;
    n = 0;
    do begin
      apb(1'b0, `IDX_DIAG, 16'h0000);
      n++;
    end while (q[15] !== 1'b0 && n < 300);
  endtask

  initial begin
    int n;
    {presetn, psel, penable, pwrite, paddr, pwdata, link_up, auto_mdix_pair} = '0;
    {partner_silent, echo_open, echo_short, nand_pins} = '0;
    res = '{2'b10, 2'b01, 2'b00};
    rows[0] = '{0, `IDX_BASIC, 16'h0000, 0, 16'h3100, 0, 7'h00};
    rows[1] = '{0, `IDX_OPMODE, 16'h0000, 0, 16'h0000, 0, 7'h00};
    rows[2] = '{0, `IDX_AFE, 16'h0000, 0, 16'h0000, 0, 7'h00};
    rows[3] = '{0, `IDX_CTRL1, 16'h0000, 0, 16'h0000, 0, 7'h00};
    rows[4] = '{0, `IDX_ENERGY_DETECT_POWERDOWN, 16'h0000, 0, 16'h0800, 0, 7'h00};
    rows[5] = '{0, `IDX_DIAG, 16'h0000, 0, 16'h0000, 0, 7'h00};
    rows[6] = '{0, `IDX_CTRL2, 16'h0000, 0, 16'h0000, 0, 7'h00};
    rows[7] = '{1, 5'h02, 16'hFFFF, 0, 16'h0000, 1, 7'h00};
    // link up before loopback is enabled
    rows[8] = '{1, `IDX_CTRL2, 16'h0004, 1, 16'h0004, 0, 7'h40};
    rows[9] = '{1, `IDX_CTRL2, 16'hFFFF, 0, 16'h6404, 0, 7'h60};
    rows[10] = '{1, `IDX_CTRL2, 16'hFFFF, 1, 16'h6404, 0, 7'h40};
    rows[11] = '{1, `IDX_CTRL2, 16'h0000, 0, 16'h0000, 0, 7'h00};
    rows[12] = '{1, `IDX_ENERGY_DETECT_POWERDOWN, 16'h0000, 0, 16'h0000, 0, 7'h10};
    rows[13] = '{1, `IDX_OPMODE, 16'h0010, 0, 16'h0010, 0, 7'h18};
    rows[14] = '{1, `IDX_ENERGY_DETECT_POWERDOWN, 16'h0800, 0, 16'h0800, 0, 7'h00};
    rows[15] = '{1, `IDX_CTRL1, 16'h0020, 0, 16'h0020, 0, 7'h01};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Register table rows
    foreach (rows[i]) begin
      link_up <= rows[i].lnk;
      if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 16'h0000);
      chk("readback", q, rows[i].rb);
      chk("slverr", {15'h0, e}, {15'h0, rows[i].err});
      repeat (2) @(posedge pclk);
      chk("modes", {9'h0, remote_loopback, power_save_active, energy_detect_powerdown,
          pll_off, powered_down, slow_osc_sel, nand_mode}, {9'h0, rows[i].outs});
    end
    // chain inputs high, then low in order
    nand_pins <= 10'h3FF;
    repeat (3) @(posedge pclk);
    chk("chain_oe", {15'h0, txd1_oe}, 16'h0001);
    chk("chain_high", {15'h0, txd1_o}, 16'h0001);
    for (int k = 0; k < 10; k++) begin
      nand_pins[k] <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("chain_out", {15'h0, txd1_o}, {15'h0, k[0]});
    end
    apb(1'b1, `IDX_CTRL1, 16'h0000);
    apb(1'b1, `IDX_CTRL2, 16'h6000);
    for (int k = 0; k < 3; k++) begin
      partner_silent <= 1'b0;
      apb(1'b1, `IDX_DIAG, 16'h8000);
      apb(1'b0, `IDX_DIAG, 16'h0000);
      chk("diag_busy", {15'h0, q[15]}, 16'h0001);
      partner_silent <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (tdr_pulse !== 1'b1 && n < 20);
      chk("tdr_pulse", {15'h0, tdr_pulse}, 16'h0001);
      chk("pair", {15'h0, tdr_pair_mdix}, 16'h0001);
      if (k < 2) begin
        repeat (20) @(posedge pclk);
        echo_short <= (k == 0);
        echo_open <= (k == 1);
        @(posedge pclk);
        echo_short <= 1'b0;
        echo_open <= 1'b0;
      end
      poll();
      chk("diag_result", {14'h0, q[14:13]}, {14'h0, res[k]});
      if (k == 2) chk("diag_dist", {7'h0, q[8:0]}, 16'h01FF);
      else chk("diag_near", {15'h0, q[8:0] >= 9'd18 && q[8:0] <= 9'd23}, 16'h0001);
      h = q;
      repeat (30) @(posedge pclk);
      apb(1'b0, `IDX_DIAG, 16'h0000);
      chk("diag_hold", q, h);
    end
    partner_silent <= 1'b0;
    apb(1'b1, `IDX_DIAG, 16'h8000);
    poll();
    chk("diag_fail", {14'h0, q[14:13]}, 16'h0003);
    // Lowest power state, serial access still served
    apb(1'b1, `IDX_AFE, 16'h0020);
    apb(1'b1, `IDX_BASIC, 16'h3900);
    repeat (2) @(posedge pclk);
    chk("slow_osc", {15'h0, slow_osc_sel}, 16'h0001);
    chk("pdn", {15'h0, powered_down}, 16'h0001);
    mgmt_master_inst.frame(1'b1, 5'h03, `IDX_BASIC, 16'h0000, 6, q);
    chk("mdio_read", q, 16'h3900);
    mgmt_master_inst.frame(1'b1, 5'h00, `IDX_BASIC, 16'h0000, 6, q);
    chk("mdio_bcast", q, 16'h3900);
    mgmt_master_inst.frame(1'b0, 5'h03, `IDX_CTRL2, 16'h0004, 9, q);
    apb(1'b0, `IDX_CTRL2, 16'h0000);
    chk("mdio_write", q, 16'h0004);
    mgmt_master_inst.frame(1'b1, 5'h05, `IDX_BASIC, 16'h0000, 6, q);
    chk("mdio_other", q, 16'hFFFF);
    // exit order: oscillator, power-down, soft reset
    apb(1'b1, `IDX_AFE, 16'h0000);
    apb(1'b1, `IDX_BASIC, 16'h3100);
    repeat (2) @(posedge pclk);
    chk("pdn_off", {15'h0, powered_down}, 16'h0000);
    chk("slow_off", {15'h0, slow_osc_sel}, 16'h0000);
    apb(1'b1, `IDX_BASIC, 16'hB100);
    repeat (2) @(posedge pclk);
    chk("soft_reset", resets[15:0], 16'h0001);
    apb(1'b0, `IDX_CTRL2, 16'h0000);
    chk("ctrl2_swrst", q, 16'h0000);
    // Second reset in mid-run
    apb(1'b1, `IDX_CTRL2, 16'h0004);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `IDX_CTRL2, 16'h0000);
    chk("ctrl2_reset", q, 16'h0000);
    finish_test();
  end
endmodule

// File: logic/mdio_slave.sv
// Serial management frame slave, sampled on the system clock
`timescale 1ns/1ps
`include "phy_diag_consts.svh"
module mdio_slave
  import phy_diag_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // Addressing
  input wire logic [4:0] phy_addr,
  input wire logic bcast_off,
  input wire logic enable,
  // Register file port
  output logic [4:0] reg_addr,
  input wire logic [15:0] rd_data,
  output logic wr_en,
  output logic [15:0] wr_data
);
  mdio_state_type state_q;
  logic mdc_q;
  logic is_rd_q;
  logic [5:0] ones_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic [4:0] addr_q;

  // Header decode on the last header bit
  wire rise = enable & mdc & ~mdc_q;
  wire [12:0] hdr = {sh_q[11:0], mdio_i};
  wire hit = (hdr[9:5] == phy_addr) | ((hdr[9:5] == 5'h00) & ~bcast_off);
  wire op_ok = (hdr[11:10] == `MD_OP_RD) | (hdr[11:10] == `MD_OP_WR);
  assign reg_addr = addr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MD_PRE;
      mdc_q <= 1'b0;
      is_rd_q <= 1'b0;
      ones_q <= 6'h00;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      addr_q <= 5'h00;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      wr_en <= 1'b0;
      wr_data <= 16'h0000;
    end else begin
      mdc_q <= mdc;
      wr_en <= 1'b0;
      if (!enable) begin
        mdio_oe <= 1'b0;
        state_q <= MD_PRE;
      end else if (rise) begin
        case (state_q)
          MD_PRE: begin
            if (mdio_i) begin
              ones_q <= (ones_q == `MD_PRE_ONES) ? ones_q : ones_q + 6'd1;
            end else begin
              ones_q <= 6'h00;
              cnt_q <= 5'h00;
              if (ones_q == `MD_PRE_ONES) state_q <= MD_HDR;
            end
          end
          MD_HDR: begin
            sh_q <= {sh_q[14:0], mdio_i};
            cnt_q <= cnt_q + 5'd1;
            if (cnt_q == 5'd12) begin
              addr_q <= hdr[4:0];
              is_rd_q <= (hdr[11:10] == `MD_OP_RD);
              state_q <= (hdr[12] & hit & op_ok) ? MD_TA : MD_PRE;
            end
          end
          MD_TA: begin
            cnt_q <= 5'h00;
            mdio_oe <= is_rd_q;
            mdio_o <= 1'b0;
            sh_q <= rd_data;
            state_q <= MD_DATA;
          end
          default: begin
            cnt_q <= cnt_q + 5'd1;
            if (is_rd_q) begin
              mdio_o <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
            end else if (cnt_q != 5'd0) begin
              sh_q <= {sh_q[14:0], mdio_i};
            end
            if (cnt_q == 5'd16) begin
              mdio_oe <= 1'b0;
              wr_en <= ~is_rd_q;
              wr_data <= {sh_q[14:0], mdio_i};
              state_q <= MD_PRE;
            end
          end
        endcase
      end
    end
  end
endmodule

// File: logic/nand_chain.sv
// Nested NAND chain for board-level pin connectivity test
`timescale 1ns/1ps
module nand_chain #(
  parameter int N = 10
) (
  // Chain inputs, first link at bit 0
  input wire logic [N-1:0] pins,
  // End of the chain
  output logic chain_out
);
  logic [N:0] link;

  // Seed of the chain
  assign link[0] = 1'b1;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_stage
      assign link[i+1] = ~(pins[i] & link[i]);
    end
  endgenerate

  assign chain_out = link[N];
endmodule

// File: logic/phy_diag_power_control.sv
// Diagnostic, board test and power mode control with APB and serial access
`timescale 1ns/1ps
`include "phy_diag_consts.svh"
module phy_diag_power_control
  import phy_diag_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  // Line status
  input wire logic link_up,
  input wire logic auto_mdix_pair,
  // Cable test front end
  input wire logic partner_silent,
  input wire logic echo_open,
  input wire logic echo_short,
  output logic tdr_pulse,
  output logic tdr_pair_mdix,
  // Board test chain
  input wire logic [9:0] nand_pins,
  output logic txd1_o,
  output logic txd1_oe,
  output logic nand_mode,
  // Mode outputs
  output logic remote_loopback,
  output logic power_save_active,
  output logic energy_detect_powerdown,
  output logic pll_off,
  output logic powered_down,
  output logic slow_osc_sel,
  output logic soft_reset_pulse
);
  logic [15:0] basic_q;
  logic [15:0] opmode_q;
  logic [15:0] afe_q;
  logic [15:0] ctrl1_q;
  logic [15:0] energy_detect_powerdown_q;
  logic [15:0] ctrl2_q;
  logic diag_busy_q;
  diag_result_type diag_res_q;
  logic [8:0] diag_dist_q;
  tdr_state_type tdr_st_q;
  logic [`QUIET_W-1:0] quiet_q;
  logic ack_q;
  logic [31:0] prdata_q;
  logic [4:0] md_addr;
  logic md_wr;
  logic [15:0] md_data;
  logic chain_out;

  // Read mux shared by both access paths, bit 16 flags a mapped index
  function automatic logic [16:0] reg_read(input logic [4:0] idx);
    logic [16:0] r;
    r = 17'h00000;
    if (idx == `IDX_BASIC) begin
      r = {1'b1, basic_q};
    end else if (idx == `IDX_OPMODE) begin
      r = {1'b1, opmode_q};
    end else if (idx == `IDX_AFE) begin
      r = {1'b1, afe_q};
    end else if (idx == `IDX_CTRL1) begin
      r = {1'b1, ctrl1_q};
    end else if (idx == `IDX_ENERGY_DETECT_POWERDOWN) begin
      r = {1'b1, energy_detect_powerdown_q};
    end else if (idx == `IDX_DIAG) begin
      r = {1'b1, diag_busy_q, diag_res_q, 4'h0, diag_dist_q};
    end else if (idx == `IDX_CTRL2) begin
      r = {1'b1, ctrl2_q};
    end
    return r;
  endfunction

  // APB decode
  wire apb_acc = psel & penable;
  wire [4:0] apb_idx = paddr[6:2];
  logic [16:0] apb_rd;
  logic [16:0] md_rd;

  // Read muxes follow every register change, not only a change of index
  always_comb begin
    apb_rd = reg_read(apb_idx);
    md_rd = reg_read(md_addr);
  end

  wire apb_hit = (paddr[11:7] == 5'h00) & (paddr[1:0] == 2'b00) & apb_rd[16];
  wire apb_wr = apb_acc & ack_q & pwrite & apb_hit;
  assign pready = ack_q;
  assign pslverr = ack_q & ~apb_hit;
  assign prdata = prdata_q;

  // APB answers one cycle into the access phase with registered data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      ack_q <= apb_acc & ~ack_q;
      if (apb_acc & ~ack_q & ~pwrite) prdata_q <= {16'h0000, apb_rd[15:0]};
    end
  end

  // Merged write port, APB has priority over a serial write
  wire wr_en = apb_wr | md_wr;
  wire [4:0] wr_idx = apb_wr ? apb_idx : md_addr;
  wire [15:0] wr_val = apb_wr ? pwdata[15:0] : md_data;
  wire wr_basic = wr_en & (wr_idx == `IDX_BASIC);
  wire wr_opmode = wr_en & (wr_idx == `IDX_OPMODE);
  wire wr_afe = wr_en & (wr_idx == `IDX_AFE);
  wire wr_ctrl1 = wr_en & (wr_idx == `IDX_CTRL1);
  wire wr_energy_detect_powerdown = wr_en & (wr_idx == `IDX_ENERGY_DETECT_POWERDOWN);
  wire wr_diag = wr_en & (wr_idx == `IDX_DIAG);
  wire wr_ctrl2 = wr_en & (wr_idx == `IDX_CTRL2);
  wire sw_rst = wr_basic & wr_val[`B_SWRST];

  // Shared status terms
  wire pd = basic_q[`B_PDN];
  wire an_en = basic_q[`B_AN];
  wire no_link = an_en & ~link_up & ~pd;
  wire go = wr_diag & wr_val[`B_DIAG_GO] & ~diag_busy_q & ~pd & ~sw_rst;

  // Serial management access stays alive in power-down
  mdio_slave u_mdio (
    .pclk(pclk),
    .presetn(presetn),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .phy_addr(phy_addr),
    .bcast_off(ctrl1_q[`B_BCASTOFF]),
    .enable(~ctrl1_q[`B_NAND]),
    .reg_addr(md_addr),
    .rd_data(md_rd[15:0]),
    .wr_en(md_wr),
    .wr_data(md_data)
  );

  // Control registers, software reset restores defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_q <= `RST_BASIC;
      opmode_q <= `RST_ZERO;
      afe_q <= `RST_ZERO;
      ctrl1_q <= `RST_ZERO;
      energy_detect_powerdown_q <= `RST_ENERGY_DETECT_POWERDOWN;
      ctrl2_q <= `RST_ZERO;
    end else if (sw_rst) begin
      basic_q <= `RST_BASIC;
      opmode_q <= `RST_ZERO;
      afe_q <= `RST_ZERO;
      ctrl1_q <= `RST_ZERO;
      energy_detect_powerdown_q <= `RST_ENERGY_DETECT_POWERDOWN;
      ctrl2_q <= `RST_ZERO;
    end else begin
      if (wr_basic) basic_q <= wr_val & `MASK_BASIC;
      if (wr_opmode) opmode_q <= wr_val & `MASK_OPMODE;
      if (wr_afe) afe_q <= wr_val & `MASK_AFE;
      if (wr_ctrl1) ctrl1_q <= wr_val & `MASK_CTRL1;
      if (wr_energy_detect_powerdown) energy_detect_powerdown_q <= wr_val & `MASK_ENERGY_DETECT_POWERDOWN;
      if (wr_ctrl2) ctrl2_q <= wr_val & `MASK_CTRL2;
    end
  end

  // cable test sequencer with self-clearing busy bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdr_st_q <= TDR_IDLE;
      diag_busy_q <= 1'b0;
      diag_res_q <= DIAG_NORMAL;
      diag_dist_q <= 9'h000;
      quiet_q <= '0;
      tdr_pulse <= 1'b0;
    end else begin
      tdr_pulse <= 1'b0;
      if (sw_rst) begin
        tdr_st_q <= TDR_IDLE;
        diag_busy_q <= 1'b0;
        diag_res_q <= DIAG_NORMAL;
        diag_dist_q <= 9'h000;
      end else if (pd & diag_busy_q) begin
        tdr_st_q <= TDR_IDLE;
        diag_busy_q <= 1'b0;
        diag_res_q <= DIAG_FAIL;
      end else begin
        case (tdr_st_q)
          TDR_IDLE: begin
            // results change only when a test starts
            if (go) begin
              diag_busy_q <= 1'b1;
              diag_res_q <= DIAG_NORMAL;
              diag_dist_q <= 9'h000;
              quiet_q <= '0;
              tdr_st_q <= TDR_QUIET;
            end
          end
          TDR_QUIET: begin
            // partner never went quiet, no measurement
            if (partner_silent) begin
              tdr_pulse <= 1'b1;
              tdr_st_q <= TDR_LISTEN;
            end else if (quiet_q == `QUIET_W'(`QUIET_CYC - 1)) begin
              diag_res_q <= DIAG_FAIL;
              diag_busy_q <= 1'b0;
              tdr_st_q <= TDR_IDLE;
            end else begin
              quiet_q <= quiet_q + `QUIET_W'(1);
            end
          end
          default: begin
            if (echo_open | echo_short) begin
              diag_res_q <= echo_short ? DIAG_SHORT : DIAG_OPEN;
              diag_busy_q <= 1'b0;
              tdr_st_q <= TDR_IDLE;
            end else if (&diag_dist_q) begin
              diag_busy_q <= 1'b0;
              tdr_st_q <= TDR_IDLE;
            end else begin
              // distance counts cycles until the echo
              diag_dist_q <= diag_dist_q + 9'd1;
            end
          end
        endcase
      end
    end
  end

  // Mode decode
  // power saving needs auto-negotiation and no link
  wire psave_d = ctrl2_q[`B_PSAVE] & no_link;
  // energy-detect power-down enabled by a zero bit
  wire energy_detect_powerdown_d = ~energy_detect_powerdown_q[`B_ENERGY_DETECT_POWERDOWN_OFF] & no_link;
  // PLL off in power-down or in automatic energy-detect mode
  wire pll_off_d = pd | (energy_detect_powerdown_d & opmode_q[`B_PLLOFF]);
  // loopback held off while powered down
  wire loop_d = ctrl2_q[`B_RLOOP] & ~pd;
  // fixed pair when automatic crossover is off
  wire pair_d = ctrl2_q[`B_AUTOX_OFF] ? ctrl2_q[`B_MDIX_SEL] : auto_mdix_pair;

  // pins arrive in chain order, MDIO at bit 0
  nand_chain #(
    .N(10)
  ) u_chain (
    .pins(nand_pins),
    .chain_out(chain_out)
  );

  // Registered mode outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_loopback <= 1'b0;
      power_save_active <= 1'b0;
      energy_detect_powerdown <= 1'b0;
      pll_off <= 1'b0;
      powered_down <= 1'b0;
      slow_osc_sel <= 1'b0;
      tdr_pair_mdix <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      remote_loopback <= loop_d;
      power_save_active <= psave_d;
      energy_detect_powerdown <= energy_detect_powerdown_d;
      pll_off <= pll_off_d;
      powered_down <= pd;
      slow_osc_sel <= afe_q[`B_SLOWOSC];
      tdr_pair_mdix <= pair_d;
      soft_reset_pulse <= sw_rst;
    end
  end

  // chain mode drives TXD1 with the chain end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nand_mode <= 1'b0;
      txd1_o <= 1'b0;
      txd1_oe <= 1'b0;
    end else begin
      nand_mode <= ctrl1_q[`B_NAND];
      txd1_o <= chain_out;
      txd1_oe <= ctrl1_q[`B_NAND];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_go;
    go;
  endsequence
  sequence s_no_quiet;
    tdr_st_q == TDR_QUIET && !partner_silent && !sw_rst && !pd
      && quiet_q == `QUIET_W'(`QUIET_CYC - 1);
  endsequence
  sequence s_echo_short;
    tdr_st_q == TDR_LISTEN && echo_short && !sw_rst && !pd;
  endsequence

  a_diag_start: assert property (s_go |=> diag_busy_q && tdr_st_q == TDR_QUIET)
    else $error("test start did not set busy");
  a_diag_fail: assert property (s_no_quiet |=> !diag_busy_q && diag_res_q == DIAG_FAIL)
    else $error("unquiet partner not reported as failed");
  a_diag_short: assert property (s_echo_short |=> diag_res_q == DIAG_SHORT && !diag_busy_q)
    else $error("short echo not reported");
  a_diag_dist: assert property (tdr_st_q == TDR_LISTEN && !echo_open && !echo_short
      && !(&diag_dist_q) && !sw_rst && !pd |=> diag_dist_q == $past(diag_dist_q) + 9'd1)
    else $error("distance count did not advance");
  a_diag_hold: assert property (!diag_busy_q && !go && !sw_rst
      |=> $stable(diag_res_q) && $stable(diag_dist_q))
    else $error("result changed between tests");
  a_loop_follow: assert property (ctrl2_q[`B_RLOOP] && !pd |=> remote_loopback)
    else $error("remote loopback not enabled");
  a_pair_manual: assert property (ctrl2_q[`B_AUTOX_OFF]
      |=> tdr_pair_mdix == $past(ctrl2_q[`B_MDIX_SEL]))
    else $error("test pair differs from manual choice");
  a_psave_gate: assert property (power_save_active |-> $past(ctrl2_q[`B_PSAVE])
      && $past(an_en) && !$past(link_up))
    else $error("power saving active without its conditions");
  a_energy_detect_powerdown_pll: assert property (energy_detect_powerdown && $past(opmode_q[`B_PLLOFF])
      |-> pll_off)
    else $error("pll left on in energy-detect power-down");
  a_pd_stop: assert property (powered_down |-> pll_off && !remote_loopback
      && !power_save_active && !energy_detect_powerdown)
    else $error("function still active in power-down");
  a_pd_exit: assert property ($fell(basic_q[`B_PDN]) |=> !powered_down)
    else $error("power-down not left");
  a_slow_osc: assert property (afe_q[`B_SLOWOSC] |=> slow_osc_sel)
    else $error("slow oscillator not selected");
  a_nand_drive: assert property (nand_mode |-> txd1_oe && !mdio_oe)
    else $error("chain output not driven");
endmodule

// File: pkg/phy_diag_consts.svh
// Register indices, field positions, reset values and timing counts
// Functional notes
// - Control 2 bit 2 loops frames from the line partner back onto the line.
// - With crossover fixed, the test runs on the manually selected pair.
// - Writing one to diag bit 15 starts a test; hardware clears it when done.
// - Result bits 14:13 give normal, open, short or failed test.
// - If the partner cannot be silenced, skip measurement and report code 11.
// - Fault distance is a 9-bit count in bits 8:0; times 0.38 gives meters.
// - Control 1 bit 5 enables the board chain test mode.
// - In chain mode the I/O pins feed nested NAND gates driving TXD1.
// - Chain order runs MDIO, MDC, RXD1, RXD0, CRS_DV, REF_CLK, irq, TXEN, LED, TXD0.
// - Each further input driven low toggles the chain output, starting high to low.
// - Control 2 bit 10 enables power saving with auto-negotiation on and no link.
// - Zero in 18h bit 11 enables energy-detect power-down under the same conditions.
// - With 10h bit 4 set, the PLL turns off during energy-detect power-down.
// - Basic control bit 11 powers down all but the management interface.
// - Clearing basic control bit 11 leaves power-down.
// - 11h bit 5 drops the reference input and selects the slow on-chip oscillator.
// - Management frames: 32 ones, start 01, read 10, write 01, addresses, turnaround, 16 bits.
`ifndef PHY_DIAG_CONSTS_SVH
`define PHY_DIAG_CONSTS_SVH

// Register indices, byte address is four times the index
`define IDX_BASIC 5'h00
`define IDX_OPMODE 5'h10
`define IDX_AFE 5'h11
`define IDX_CTRL1 5'h16
`define IDX_ENERGY_DETECT_POWERDOWN 5'h18
`define IDX_DIAG 5'h1D
`define IDX_CTRL2 5'h1F

// Writable bits and reset values
`define MASK_BASIC 16'h3900
`define MASK_OPMODE 16'h0010
`define MASK_AFE 16'h0020
`define MASK_CTRL1 16'h0220
`define MASK_ENERGY_DETECT_POWERDOWN 16'h0800
`define MASK_CTRL2 16'h6404
`define RST_BASIC 16'h3100
`define RST_ENERGY_DETECT_POWERDOWN 16'h0800
`define RST_ZERO 16'h0000

// Field positions
`define B_SWRST 15
`define B_AN 12
`define B_PDN 11
`define B_PLLOFF 4
`define B_SLOWOSC 5
`define B_NAND 5
`define B_BCASTOFF 9
`define B_ENERGY_DETECT_POWERDOWN_OFF 11
`define B_DIAG_GO 15
`define B_MDIX_SEL 14
`define B_AUTOX_OFF 13
`define B_PSAVE 10
`define B_RLOOP 2

// Management frame fields
`define MD_PRE_ONES 6'd32
`define MD_OP_RD 2'b10
`define MD_OP_WR 2'b01

// Timing
`define CLK_NS 20
`define QUIET_NS 10000
`define QUIET_CYC ((`QUIET_NS + `CLK_NS - 1) / `CLK_NS)
`define QUIET_W 10

`endif

// File: pkg/phy_diag_pkg.sv
// Types shared by the diagnostic and power control logic
package phy_diag_pkg;
  typedef enum logic [1:0] {
    DIAG_NORMAL = 2'b00,
    DIAG_OPEN = 2'b01,
    DIAG_SHORT = 2'b10,
    DIAG_FAIL = 2'b11
  } diag_result_type;
  typedef enum logic [1:0] {
    TDR_IDLE = 2'b00,
    TDR_QUIET = 2'b01,
    TDR_LISTEN = 2'b10
  } tdr_state_type;
  typedef enum logic [1:0] {
    MD_PRE = 2'b00,
    MD_HDR = 2'b01,
    MD_TA = 2'b10,
    MD_DATA = 2'b11
  } mdio_state_type;
endpackage
